// ==== inc/dbc_consts.svh ====
`ifndef DBC_CONSTS_SVH
`define DBC_CONSTS_SVH

// Command codes, size field in bits 3:2
`define DBC_CMD_NOP        8'h00
`define DBC_CMD_GO         8'h08
`define DBC_CMD_GO_UNTIL   8'h0c
`define DBC_CMD_WRM_BASE   8'h10
`define DBC_CMD_FILL_BASE  8'h12
`define DBC_CMD_RDM_BASE   8'h30
`define DBC_CMD_DUMP_BASE  8'h32
`define DBC_CMD_FAMILY_MSK 8'hf2
`define DBC_CMD_WS_BIT     0
`define DBC_CMD_SZ_LSB     2

// Operand size field values
`define DBC_SZ_BYTE        2'h0
`define DBC_SZ_WORD        2'h1
`define DBC_SZ_LONG        2'h2

// Address bytes after an addressed command
`define DBC_ADDR_BYTES     3'h3

// Register offsets
`define DBC_REG_CTRL       4'h0
`define DBC_REG_STATUS     4'h4
`define DBC_REG_TADDR      4'h8

// Register fields and reset values
`define DBC_CTRL_ACK_EN    0
`define DBC_STAT_ILLEGAL   0
`define DBC_STAT_HALTED    1
`define DBC_STAT_BUSY      2
`define DBC_CTRL_RESET     1'h0

`endif

// ==== inc/dbc_pkg.sv ====
package dbc_pkg;

	typedef enum logic [3:0] {
		DBC_ST_IDLE    = 4'b0000,
		DBC_ST_ADDR    = 4'b0001,
		DBC_ST_WDATA   = 4'b0010,
		DBC_ST_MEM     = 4'b0011,
		DBC_ST_STAT    = 4'b0100,
		DBC_ST_RDATA   = 4'b0101,
		DBC_ST_GOLEAVE = 4'b0110,
		DBC_ST_GOWAIT  = 4'b0111
	} dbc_state_e;

	typedef enum logic [2:0] {
		DBC_PREV_OTHER = 3'b000,
		DBC_PREV_SYNC  = 3'b001,
		DBC_PREV_NOP   = 3'b010,
		DBC_PREV_RDM   = 3'b011,
		DBC_PREV_DUMP  = 3'b100,
		DBC_PREV_WRM   = 3'b101,
		DBC_PREV_FILL  = 3'b110
	} dbc_prev_e;

endpackage

// ==== rtl/dbc_block_cmds.sv ====
`include "dbc_consts.svh"

module dbc_block_cmds #(
	parameter int ADDR_W = 24
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Framed command stream from the serial layer
	input  wire logic              sync_event,
	input  wire logic              cmd_valid,
	input  wire logic [7:0]        cmd_code,
	input  wire logic              rx_valid,
	input  wire logic [7:0]        rx_byte,
	output logic                   tx_valid,
	output logic [7:0]             tx_byte,
	input  wire logic              tx_ready,
	output logic                   ack_pulse,
	output logic                   illegal_resp,
	// Status byte supplied by the control block
	input  wire logic [7:0]        status_low_byte,
	// Memory access port
	output logic                   mem_req,
	output logic                   mem_we,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic [1:0]             mem_size,
	output logic [31:0]            mem_wdata,
	input  wire logic              mem_done,
	input  wire logic [31:0]       mem_rdata,
	// CPU run control
	input  wire logic              debug_halt_state,
	output logic                   cpu_resume,
	// Register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata
);

	// Only a 24-bit pointer is served
	if (ADDR_W != 24) begin
		$error("dbc_block_cmds supports ADDR_W of 24 only");
	end

	dbc_pkg::dbc_state_e state;
	dbc_pkg::dbc_prev_e  prev;
	logic [ADDR_W-1:0]   temp_addr;
	logic [31:0]         shift_buf;
	logic [2:0]          byte_cnt;
	logic                op_write;
	logic                op_ws;
	logic                op_addressed;
	logic                ack_en;
	logic                illegal_command_flag;

	// Operand bytes for a size field
	function automatic logic [2:0] size_bytes(input logic [1:0] sz);
		case (sz)
			`DBC_SZ_BYTE: size_bytes = 3'h1;
			`DBC_SZ_WORD: size_bytes = 3'h2;
			default:      size_bytes = 3'h4;
		endcase
	endfunction

	// Longword accesses aligned to four
	function automatic logic [ADDR_W-1:0] align_addr(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
		if (sz == `DBC_SZ_LONG) begin
			align_addr = {a[ADDR_W-1:2], 2'h0};
		end else begin
			align_addr = a;
		end
	endfunction

	// Write strobe aimed at one register offset
	function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] off);
		wr_hit = wr && (a == off);
	endfunction

	logic [1:0] cmd_sz;
	logic [7:0] cmd_family;
	logic       cmd_ws;
	logic       read_chain_ok;
	logic       write_chain_ok;
	logic       busy;
	logic [31:0] status_word;

	assign cmd_sz     = cmd_code[`DBC_CMD_SZ_LSB +: 2];
	assign cmd_family = cmd_code & `DBC_CMD_FAMILY_MSK;
	assign cmd_ws     = cmd_code[`DBC_CMD_WS_BIT];

	// Predecessor checks for block commands
	assign read_chain_ok = (prev == dbc_pkg::DBC_PREV_SYNC) || (prev == dbc_pkg::DBC_PREV_NOP)
		|| (prev == dbc_pkg::DBC_PREV_RDM) || (prev == dbc_pkg::DBC_PREV_DUMP);
	assign write_chain_ok = (prev == dbc_pkg::DBC_PREV_SYNC) || (prev == dbc_pkg::DBC_PREV_NOP)
		|| (prev == dbc_pkg::DBC_PREV_WRM) || (prev == dbc_pkg::DBC_PREV_FILL);

	// Status word seen by software
	assign busy        = (state != dbc_pkg::DBC_ST_IDLE);
	assign status_word = {29'h0, busy, debug_halt_state, illegal_command_flag};

	// Command sequencer and datapath
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state        <= dbc_pkg::DBC_ST_IDLE;
			prev         <= dbc_pkg::DBC_PREV_OTHER;
			shift_buf    <= 32'h0;
			byte_cnt     <= 3'h0;
			op_write     <= 1'b0;
			op_ws        <= 1'b0;
			op_addressed <= 1'b0;
			tx_valid     <= 1'b0;
			tx_byte      <= 8'h00;
			ack_pulse    <= 1'b0;
			illegal_resp <= 1'b0;
			mem_req      <= 1'b0;
			mem_we       <= 1'b0;
			mem_addr     <= '0;
			mem_size     <= 2'h0;
			mem_wdata    <= 32'h0;
			cpu_resume   <= 1'b0;
		end else begin
			ack_pulse    <= 1'b0;
			illegal_resp <= 1'b0;
			cpu_resume   <= 1'b0;
			if (sync_event) begin
				state    <= dbc_pkg::DBC_ST_IDLE;
				prev     <= dbc_pkg::DBC_PREV_SYNC;
				mem_req  <= 1'b0;
				tx_valid <= 1'b0;
			end else begin
				case (state)
					dbc_pkg::DBC_ST_IDLE: begin
						if (cmd_valid) begin
							mem_size  <= cmd_sz;
							op_ws     <= cmd_ws;
							shift_buf <= 32'h0;
							if (cmd_code == `DBC_CMD_NOP) begin
								prev <= dbc_pkg::DBC_PREV_NOP;
							end else if (cmd_code == `DBC_CMD_GO || cmd_code == `DBC_CMD_GO_UNTIL) begin
								prev <= dbc_pkg::DBC_PREV_OTHER;
								if (!debug_halt_state) begin
									illegal_resp <= 1'b1;
								end else begin
									cpu_resume <= 1'b1;
									if (ack_en && cmd_code == `DBC_CMD_GO_UNTIL) begin
										state <= dbc_pkg::DBC_ST_GOLEAVE;
									end else begin
										ack_pulse <= ack_en;
									end
								end
							end else if (cmd_family == `DBC_CMD_RDM_BASE || cmd_family == `DBC_CMD_WRM_BASE) begin
								op_write     <= (cmd_family == `DBC_CMD_WRM_BASE);
								op_addressed <= 1'b1;
								byte_cnt     <= `DBC_ADDR_BYTES;
								state        <= dbc_pkg::DBC_ST_ADDR;
							end else if (cmd_family == `DBC_CMD_DUMP_BASE) begin
								op_write     <= 1'b0;
								op_addressed <= 1'b0;
								if (read_chain_ok) begin
									mem_addr <= align_addr(temp_addr, cmd_sz);
									mem_we   <= 1'b0;
									mem_req  <= 1'b1;
									state    <= dbc_pkg::DBC_ST_MEM;
								end else begin
									illegal_resp <= 1'b1;
									prev         <= dbc_pkg::DBC_PREV_OTHER;
								end
							end else if (cmd_family == `DBC_CMD_FILL_BASE) begin
								op_write     <= 1'b1;
								op_addressed <= 1'b0;
								if (write_chain_ok) begin
									mem_addr <= align_addr(temp_addr, cmd_sz);
									byte_cnt <= size_bytes(cmd_sz);
									state    <= dbc_pkg::DBC_ST_WDATA;
								end else begin
									illegal_resp <= 1'b1;
									prev         <= dbc_pkg::DBC_PREV_OTHER;
								end
							end else begin
								prev <= dbc_pkg::DBC_PREV_OTHER;
							end
						end
					end
					dbc_pkg::DBC_ST_ADDR: begin
						if (rx_valid) begin
							shift_buf <= {shift_buf[23:0], rx_byte};
							byte_cnt  <= byte_cnt - 3'h1;
							if (byte_cnt == 3'h1) begin
								mem_addr <= align_addr({shift_buf[15:0], rx_byte}, mem_size);
								if (op_write) begin
									byte_cnt  <= size_bytes(mem_size);
									shift_buf <= 32'h0;
									state     <= dbc_pkg::DBC_ST_WDATA;
								end else begin
									mem_we  <= 1'b0;
									mem_req <= 1'b1;
									state   <= dbc_pkg::DBC_ST_MEM;
								end
							end
						end
					end
					dbc_pkg::DBC_ST_WDATA: begin
						if (rx_valid) begin
							shift_buf <= {shift_buf[23:0], rx_byte};
							byte_cnt  <= byte_cnt - 3'h1;
							if (byte_cnt == 3'h1) begin
								mem_wdata <= {shift_buf[23:0], rx_byte};
								mem_we    <= 1'b1;
								mem_req   <= 1'b1;
								state     <= dbc_pkg::DBC_ST_MEM;
							end
						end
					end
					dbc_pkg::DBC_ST_MEM: begin
						if (mem_done) begin
							mem_req   <= 1'b0;
							ack_pulse <= ack_en;
							if (op_write) begin
								prev <= op_addressed ? dbc_pkg::DBC_PREV_WRM : dbc_pkg::DBC_PREV_FILL;
							end else begin
								prev <= op_addressed ? dbc_pkg::DBC_PREV_RDM : dbc_pkg::DBC_PREV_DUMP;
							end
							shift_buf <= mem_rdata << (6'd32 - {size_bytes(mem_size), 3'h0});
							byte_cnt  <= size_bytes(mem_size);
							if (op_ws) begin
								state <= dbc_pkg::DBC_ST_STAT;
							end else if (op_write) begin
								state <= dbc_pkg::DBC_ST_IDLE;
							end else begin
								state <= dbc_pkg::DBC_ST_RDATA;
							end
						end
					end
					dbc_pkg::DBC_ST_STAT: begin
						if (tx_valid && tx_ready) begin
							tx_valid <= 1'b0;
							state    <= op_write ? dbc_pkg::DBC_ST_IDLE : dbc_pkg::DBC_ST_RDATA;
						end else if (!tx_valid) begin
							tx_valid <= 1'b1;
							tx_byte  <= status_low_byte;
						end
					end
					dbc_pkg::DBC_ST_RDATA: begin
						if (tx_valid && tx_ready) begin
							tx_valid  <= 1'b0;
							shift_buf <= {shift_buf[23:0], 8'h00};
							byte_cnt  <= byte_cnt - 3'h1;
							if (byte_cnt == 3'h1) begin
								state <= dbc_pkg::DBC_ST_IDLE;
							end
						end else if (!tx_valid) begin
							tx_valid <= 1'b1;
							tx_byte  <= shift_buf[31:24];
						end
					end
					dbc_pkg::DBC_ST_GOLEAVE: begin
						if (!debug_halt_state) begin
							state <= dbc_pkg::DBC_ST_GOWAIT;
						end
					end
					dbc_pkg::DBC_ST_GOWAIT: begin
						if (debug_halt_state) begin
							ack_pulse <= 1'b1;
							state     <= dbc_pkg::DBC_ST_IDLE;
						end
					end
					default: begin
						state <= dbc_pkg::DBC_ST_IDLE;
					end
				endcase
			end
		end
	end

	// Temporary address, advanced after each finished access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_addr <= '0;
		end else if (!sync_event && state == dbc_pkg::DBC_ST_MEM && mem_done) begin
			temp_addr <= mem_addr + {{(ADDR_W-3){1'b0}}, size_bytes(mem_size)};
		end
	end

	// Handshake enable control
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_en <= `DBC_CTRL_RESET;
		end else if (wr_hit(reg_wr, reg_addr, `DBC_REG_CTRL)) begin
			ack_en <= reg_wdata[`DBC_CTRL_ACK_EN];
		end
	end

	// Illegal command flag, write one to clear, set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			illegal_command_flag <= 1'b0;
		end else if (illegal_resp) begin
			illegal_command_flag <= 1'b1;
		end else if (wr_hit(reg_wr, reg_addr, `DBC_REG_STATUS) && reg_wdata[`DBC_STAT_ILLEGAL]) begin
			illegal_command_flag <= 1'b0;
		end
	end

	// Register read data, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				`DBC_REG_CTRL:   reg_rdata <= {31'h0, ack_en};
				`DBC_REG_STATUS: reg_rdata <= status_word;
				`DBC_REG_TADDR:  reg_rdata <= {{(32-ADDR_W){1'b0}}, temp_addr};
				default:         reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

endmodule

// ==== tb/dbc_block_monitor.sv ====
`include "dbc_consts.svh"

module dbc_block_monitor #(
	parameter int ADDR_W = 24
) (
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// Command stream
	input wire logic              cmd_valid,
	input wire logic [7:0]        cmd_code,
	input wire logic              tx_valid,
	input wire logic [7:0]        tx_byte,
	input wire logic              tx_ready,
	input wire logic              ack_pulse,
	input wire logic              illegal_resp,
	// Memory and CPU
	input wire logic              mem_req,
	input wire logic              mem_we,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic [1:0]        mem_size,
	input wire logic              mem_done,
	input wire logic              debug_halt_state,
	input wire logic              cpu_resume
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       idle_cmd;
	logic       go_cmd;
	logic [1:0] cmd_sz;
	assign idle_cmd = cmd_valid && !mem_req && !tx_valid;
	assign go_cmd = idle_cmd && (cmd_code == `DBC_CMD_GO || cmd_code == `DBC_CMD_GO_UNTIL);
	assign cmd_sz = cmd_code[`DBC_CMD_SZ_LSB +: 2];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_go_refused: assert property (go_cmd && !debug_halt_state |=> illegal_resp && !cpu_resume)
		else $error("resume taken while running");
	chk_go_resume: assert property (go_cmd && debug_halt_state |=> cpu_resume && !illegal_resp)
		else $error("resume not issued");
	chk_nop_quiet: assert property (idle_cmd && cmd_code == `DBC_CMD_NOP |=> (!mem_req && !cpu_resume && !ack_pulse)[*2])
		else $error("no-op had an effect");
	chk_size_decode: assert property ($rose(mem_req) && $past(cmd_valid) |-> mem_size == $past(cmd_sz) && !mem_we)
		else $error("operand size not decoded");
	chk_access_hold: assert property (mem_req && !mem_done |=> mem_req && $stable(mem_addr))
		else $error("access dropped or moved");
	chk_long_align: assert property (mem_req && mem_size == `DBC_SZ_LONG |-> mem_addr[1:0] == 2'h0)
		else $error("longword access misaligned");
	chk_ack_cause: assert property (ack_pulse |-> cpu_resume || $past(mem_done) || $past(debug_halt_state))
		else $error("acknowledge without cause");
	chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("byte lost while stalled");
	chk_illegal_idle: assert property (illegal_resp |=> !mem_req && !tx_valid)
		else $error("refused command made an access");
	cover property (ack_pulse && !cpu_resume);
	cover property (illegal_resp);
	cover property (cpu_resume && ack_pulse);
endmodule

// ==== tb/dbc_mem_model.sv ====
module dbc_mem_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Memory port
	input  wire logic        mem_req,
	input  wire logic [23:0] mem_addr,
	output logic             mem_done,
	output logic [31:0]      mem_rdata,
	// Serial layer and status
	output logic             tx_ready,
	output logic [7:0]       status_low_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0]  wait_cnt;
	logic [31:0] pat;
	assign pat = {24'h112233, mem_addr[7:0]};
	assign mem_rdata = mem_done ? pat : ~pat;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_done <= 1'b0;
			wait_cnt <= 2'h0;
			tx_ready <= 1'b0;
			status_low_byte <= 8'h00;
		end else begin
			tx_ready <= ~tx_ready;
			mem_done <= 1'b0;
			if (mem_req && !mem_done) begin
				wait_cnt <= wait_cnt + 2'h1;
				if (wait_cnt == {mem_addr[2], 1'b0}) begin
					mem_done <= 1'b1;
					wait_cnt <= 2'h0;
					status_low_byte <= status_low_byte + 8'h01;
				end
			end
		end
	end
endmodule

// ==== tb/tb_dbc_block_cmds.sv ====
`include "dbc_consts.svh"

module tb_dbc_block_cmds;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rst_n = 0, sync_event = 0, cmd_valid = 0, rx_valid = 0;
	logic        reg_wr = 0, reg_rd = 0, debug_halt_state = 0;
	logic [7:0]  cmd_code = 8'h00, rx_byte = 8'h00, tx_byte, status_low_byte;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, mem_rdata, reg_rdata, mem_wdata;
	logic        tx_valid, tx_ready, ack_pulse, illegal_resp, mem_req, mem_we, mem_done, cpu_resume;
	logic [23:0] mem_addr;
	logic [1:0]  mem_size;
	int          fail_count = 0, checked = 0, nacc = 0, i, j;
	int          ev[$], e[$];
	logic [58:0] acc[$];
	logic [31:0] rows[7] = '{32'h39000120, 32'h30000105, 32'h37000106, 32'h00000000,
		32'h3a000108, 32'h3300010c, 32'h3b00010c};
	dbc_block_cmds dut_u (
		.clk              (clk),
		.rst_n            (rst_n),
		.sync_event       (sync_event),
		.cmd_valid        (cmd_valid),
		.cmd_code         (cmd_code),
		.rx_valid         (rx_valid),
		.rx_byte          (rx_byte),
		.tx_valid         (tx_valid),
		.tx_byte          (tx_byte),
		.tx_ready         (tx_ready),
		.ack_pulse        (ack_pulse),
		.illegal_resp     (illegal_resp),
		.status_low_byte  (status_low_byte),
		.mem_req          (mem_req),
		.mem_we           (mem_we),
		.mem_addr         (mem_addr),
		.mem_size         (mem_size),
		.mem_wdata        (mem_wdata),
		.mem_done         (mem_done),
		.mem_rdata        (mem_rdata),
		.debug_halt_state (debug_halt_state),
		.cpu_resume       (cpu_resume),
		.reg_addr         (reg_addr),
		.reg_wdata        (reg_wdata),
		.reg_wr           (reg_wr),
		.reg_rd           (reg_rd),
		.reg_rdata        (reg_rdata)
	);
	dbc_mem_model mem_u (
		.clk             (clk),
		.rst_n           (rst_n),
		.mem_req         (mem_req),
		.mem_addr        (mem_addr),
		.mem_done        (mem_done),
		.mem_rdata       (mem_rdata),
		.tx_ready        (tx_ready),
		.status_low_byte (status_low_byte)
	);
	always #2 clk = ~clk;
	always @(posedge clk) begin
		if (ack_pulse) ev.push_back(256);
		if (tx_valid && tx_ready) ev.push_back(tx_byte);
		if (illegal_resp) ev.push_back(512);
		if (cpu_resume) ev.push_back(1024);
		if (mem_req && mem_done) acc.push_back({mem_we, mem_size, mem_addr, mem_we ? mem_wdata : 32'h0});
	end
	task chk(string n, logic [58:0] x, logic [58:0] s);
		checked++;
		if (s !== x) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, x, s);
		end
	endtask
	task send(logic c, logic [7:0] v);
		@(posedge clk);
		cmd_valid <= c;
		rx_valid <= !c;
		cmd_code <= v;
		rx_byte <= v;
		@(posedge clk);
		cmd_valid <= 1'b0;
		rx_valid <= 1'b0;
	endtask
	task reg_op(logic w, logic [3:0] a, logic [31:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
		if (!w) chk("register", d, reg_rdata);
	endtask
	task fin(logic [58:0] xa, int na);
		for (j = 0; j < 400 && ev.size() < e.size(); j++) @(posedge clk);
		repeat (6) @(posedge clk);
		chk("events", e.size(), ev.size());
		foreach (e[k]) chk("event", e[k], ev[k]);
		chk("accesses", na, acc.size());
		if (na > 0) chk("access", xa, acc[0]);
		ev.delete();
		e.delete();
		acc.delete();
	endtask
	task complete_run;
		if (fail_count == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		reg_op(0, `DBC_REG_STATUS, 32'h0);
		reg_op(0, `DBC_REG_CTRL, 32'h0);
		reg_op(0, 4'hc, 32'h0);
		send(1, `DBC_CMD_DUMP_BASE);
		e = {512};
		fin(0, 0);
		reg_op(0, `DBC_REG_STATUS, 32'h1);
		reg_op(1, `DBC_REG_STATUS, 32'h1);
		reg_op(0, `DBC_REG_STATUS, 32'h0);
		reg_op(1, `DBC_REG_CTRL, 32'h1);
		for (i = 0; i < 7; i++) begin
			send(1, rows[i][31:24]);
			if ((rows[i][31:24] & `DBC_CMD_FAMILY_MSK) == `DBC_CMD_RDM_BASE)
				for (j = 16; j >= 0; j -= 8) send(0, rows[i][j +: 8]);
			if (rows[i][31:24] != 8'h00) begin
				nacc++;
				e.push_back(256);
				if (rows[i][24]) e.push_back(nacc);
				for (j = (8 << rows[i][27:26]) - 8; j >= 0; j -= 8) e.push_back(8'({24'h112233, rows[i][7:0]} >> j));
			end
			fin({1'b0, rows[i][27:26], rows[i][23:0], 32'h0}, rows[i][31:24] != 8'h00);
		end
		send(1, `DBC_CMD_FILL_BASE);
		e = {512};
		fin(0, 0);
		reg_op(0, `DBC_REG_TADDR, 32'h110);
		reg_op(1, `DBC_REG_STATUS, 32'h1);
		send(1, `DBC_CMD_WRM_BASE);
		for (j = 16; j >= 0; j -= 8) send(0, 8'(24'h000200 >> j));
		send(0, 8'ha7);
		nacc++;
		e = {256};
		fin({1'b1, 2'h0, 24'h200, 32'ha7}, 1);
		send(1, 8'h17);
		send(0, 8'hbe);
		send(0, 8'hef);
		nacc++;
		e = {256, nacc};
		fin({1'b1, 2'h1, 24'h201, 32'hbeef}, 1);
		reg_op(0, `DBC_REG_TADDR, 32'h203);
		send(1, `DBC_CMD_DUMP_BASE);
		e = {512};
		fin(0, 0);
		send(1, `DBC_CMD_GO);
		e = {512};
		fin(0, 0);
		send(1, `DBC_CMD_GO_UNTIL);
		e = {512};
		fin(0, 0);
		debug_halt_state <= 1'b1;
		send(1, `DBC_CMD_GO);
		debug_halt_state <= 1'b0;
		e = {256, 1024};
		fin(0, 0);
		debug_halt_state <= 1'b1;
		send(1, `DBC_CMD_GO_UNTIL);
		debug_halt_state <= 1'b0;
		e = {1024};
		fin(0, 0);
		repeat (300) @(posedge clk);
		reg_op(0, `DBC_REG_STATUS, 32'h5);
		chk("early ack", 0, ev.size());
		debug_halt_state <= 1'b1;
		e = {256};
		fin(0, 0);
		reg_op(1, `DBC_REG_CTRL, 32'h0);
		send(1, `DBC_CMD_GO_UNTIL);
		debug_halt_state <= 1'b0;
		e = {1024};
		fin(0, 0);
		debug_halt_state <= 1'b1;
		fin(0, 0);
		reg_op(1, `DBC_REG_CTRL, 32'h1);
		send(1, `DBC_CMD_GO_UNTIL);
		debug_halt_state <= 1'b0;
		e = {1024};
		fin(0, 0);
		@(posedge clk);
		sync_event <= 1'b1;
		@(posedge clk);
		sync_event <= 1'b0;
		send(1, `DBC_CMD_DUMP_BASE);
		nacc++;
		e = {256, 8'h03};
		fin({1'b0, 2'h0, 24'h203, 32'h0}, 1);
		complete_run();
	end
endmodule

bind dbc_block_cmds dbc_block_monitor #(.ADDR_W(ADDR_W)) chk_u (
	.clk              (clk),
	.rst_n            (rst_n),
	.cmd_valid        (cmd_valid),
	.cmd_code         (cmd_code),
	.tx_valid         (tx_valid),
	.tx_byte          (tx_byte),
	.tx_ready         (tx_ready),
	.ack_pulse        (ack_pulse),
	.illegal_resp     (illegal_resp),
	.mem_req          (mem_req),
	.mem_we           (mem_we),
	.mem_addr         (mem_addr),
	.mem_size         (mem_size),
	.mem_done         (mem_done),
	.debug_halt_state (debug_halt_state),
	.cpu_resume       (cpu_resume)
);
